// File: pkg/lcdbk_pkg.sv
// Constants and types shared by the display driver serial front end
package lcdbk_pkg;
  localparam logic [5:0] LCDBK_SLAVE_ADDR_HI = 6'h1c;
  localparam logic [5:0] LCDBK_RAM_LAST = 6'h27;
  localparam logic [1:0] LCDBK_MODE_STATIC = 2'h1;
  localparam logic [1:0] LCDBK_MODE_MUX2 = 2'h2;
  localparam logic [1:0] LCDBK_MODE_MUX3 = 2'h3;
  localparam logic [1:0] LCDBK_MODE_MUX4 = 2'h0;
  localparam logic [1:0] LCDBK_MODE_RST = 2'h1;
  localparam logic [11:0] LCDBK_BLINK_DIV1 = 12'h300;
  localparam logic [11:0] LCDBK_BLINK_DIV2 = 12'h600;
  localparam logic [11:0] LCDBK_BLINK_DIV3 = 12'hc00;
  localparam logic [2:0] LCDBK_OP_BANK = 3'h7;
  typedef enum logic [4:0] {
    LCDBK_IDLE = 5'b00001,
    LCDBK_SHIFT = 5'b00010,
    LCDBK_ACK = 5'b00100,
    LCDBK_ACK_END = 5'b01000,
    LCDBK_IGNORE = 5'b10000
  } lcdbk_state_e;
endpackage : lcdbk_pkg

// File: logic/lcdbk_blinker.sv
// Blink divider producing a square phase from the display clock tick
`timescale 1ns/1ps
`default_nettype none
module lcdbk_blinker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic disp_tick_i,
  input wire logic [1:0] rate_i,
  output logic phase_o
);
  logic [11:0] cnt_reg;
  logic [11:0] half;
  always_comb begin
    unique case (rate_i)
      2'h1: half = lcdbk_pkg::LCDBK_BLINK_DIV1 >> 1;
      2'h2: half = lcdbk_pkg::LCDBK_BLINK_DIV2 >> 1;
      2'h3: half = lcdbk_pkg::LCDBK_BLINK_DIV3 >> 1;
      default: half = 12'h000;
    endcase
  end
  // Equal halves: toggle every half blink period, counted in display clock ticks
  always_ff @(posedge clock_i) begin
    if (rst_i || rate_i == 2'h0) begin
      cnt_reg <= 12'h000;
      phase_o <= 1'b0;
    end else if (disp_tick_i) begin
      if (cnt_reg >= half - 12'h001) begin
        cnt_reg <= 12'h000;
        phase_o <= ~phase_o;
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end
  end
endmodule : lcdbk_blinker
`default_nettype wire

// File: logic/lcdbk_front.sv
// Serial slave front end, display RAM, bank selectors and blinker
`timescale 1ns/1ps
`default_nettype none
module lcdbk_front (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_addr_strap_i,
  input wire logic hw_subaddr_pin_0_i,
  input wire logic hw_subaddr_pin_1_i,
  input wire logic hw_subaddr_pin_2_i,
  input wire logic disp_tick_i,
  input wire logic [1:0] bp_index_i,
  input wire logic [5:0] seg_col_i,
  output logic seg_bit_o,
  output logic disp_enable_o,
  output logic [1:0] drive_mode_o,
  output logic bias_half_o,
  output logic blink_phase_o
);
  lcdbk_pkg::lcdbk_state_e state_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic addr_phase_reg;
  logic cmd_phase_reg;
  logic ack_this_reg;
  logic [5:0] ptr_reg;
  logic [2:0] subaddr_reg;
  logic in_bank_reg;
  logic out_bank_reg;
  logic blink_alt_reg;
  logic [1:0] blink_rate_field_reg;
  logic [3:0] ram [0:39];
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] byte_rx;
  logic [2:0] hw_subaddr;
  logic sub_match;
  logic [3:0] ptr_step;
  logic [6:0] ptr_sum;
  logic blink_phase;
  logic out_alt;
  logic [1:0] row_sel;
  logic [3:0] row_word;

  assign start_det = scl_i && scl_d_reg && sda_d_reg && !sda_i;
  assign stop_det = scl_i && scl_d_reg && !sda_d_reg && sda_i;
  assign scl_rise = scl_i && !scl_d_reg;
  assign scl_fall = !scl_i && scl_d_reg;
  assign byte_rx = shift_reg;
  assign hw_subaddr = {hw_subaddr_pin_2_i, hw_subaddr_pin_1_i, hw_subaddr_pin_0_i};
  assign sub_match = subaddr_reg == hw_subaddr;
  assign sda_o = 1'b0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_i;
      sda_d_reg <= sda_i;
    end
  end

  // Bit and byte sequencing; SDA sampled on SCL rise, stable while high
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= lcdbk_pkg::LCDBK_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      addr_phase_reg <= 1'b0;
      ack_this_reg <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state_reg <= lcdbk_pkg::LCDBK_SHIFT;
      bit_cnt_reg <= 4'h0;
      addr_phase_reg <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state_reg <= lcdbk_pkg::LCDBK_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      unique case (state_reg)
        lcdbk_pkg::LCDBK_IDLE, lcdbk_pkg::LCDBK_IGNORE: begin
          sda_oe_o <= 1'b0;
        end
        lcdbk_pkg::LCDBK_SHIFT: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_i};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (addr_phase_reg) begin
              addr_phase_reg <= 1'b0;
              // Write only, address bit 1 from strap
              if (byte_rx[7:2] == lcdbk_pkg::LCDBK_SLAVE_ADDR_HI
                  && byte_rx[1] == slave_addr_strap_i && !byte_rx[0]) begin
                sda_oe_o <= 1'b1;
                ack_this_reg <= 1'b1;
                state_reg <= lcdbk_pkg::LCDBK_ACK;
              end else begin
                state_reg <= lcdbk_pkg::LCDBK_IGNORE;
              end
            end else begin
              sda_oe_o <= cmd_phase_reg || sub_match;
              state_reg <= lcdbk_pkg::LCDBK_ACK;
            end
          end
        end
        lcdbk_pkg::LCDBK_ACK: begin
          if (scl_rise) begin
            state_reg <= lcdbk_pkg::LCDBK_ACK_END;
          end
        end
        lcdbk_pkg::LCDBK_ACK_END: begin
          // Hold ack through whole high phase, release after fall
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            ack_this_reg <= 1'b0;
            state_reg <= lcdbk_pkg::LCDBK_SHIFT;
          end
        end
        default: state_reg <= lcdbk_pkg::LCDBK_IDLE;
      endcase
    end
  end

  logic byte_done;
  assign byte_done = (state_reg == lcdbk_pkg::LCDBK_SHIFT) && scl_fall
                     && bit_cnt_reg == 4'h8 && !addr_phase_reg;

  // Command/data split by continuation bit; restarts with commands
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd_phase_reg <= 1'b1;
    end else if (start_det) begin
      cmd_phase_reg <= 1'b1;
    end else if (byte_done && cmd_phase_reg && !byte_rx[7]) begin
      cmd_phase_reg <= 1'b0;
    end
  end

  // Command decode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      disp_enable_o <= 1'b0;
      bias_half_o <= 1'b0;
      drive_mode_o <= lcdbk_pkg::LCDBK_MODE_RST;
      in_bank_reg <= 1'b0;
      out_bank_reg <= 1'b0;
      blink_alt_reg <= 1'b0;
      blink_rate_field_reg <= 2'h0;
    end else if (byte_done && cmd_phase_reg) begin
      if (byte_rx[6:5] == 2'h2) begin
        disp_enable_o <= byte_rx[3];
        bias_half_o <= byte_rx[2];
        drive_mode_o <= byte_rx[1:0];
      end else if (byte_rx[6:2] == {lcdbk_pkg::LCDBK_OP_BANK, 2'h2}) begin
        in_bank_reg <= byte_rx[1];
        out_bank_reg <= byte_rx[0];
      end else if (byte_rx[6:3] == 4'he) begin
        blink_alt_reg <= byte_rx[2];
        blink_rate_field_reg <= byte_rx[1:0];
      end
    end
  end

  always_comb begin
    unique case (drive_mode_o)
      lcdbk_pkg::LCDBK_MODE_STATIC: ptr_step = 4'h8;
      lcdbk_pkg::LCDBK_MODE_MUX2: ptr_step = 4'h4;
      lcdbk_pkg::LCDBK_MODE_MUX3: ptr_step = 4'h3;
      lcdbk_pkg::LCDBK_MODE_MUX4: ptr_step = 4'h2;
    endcase
  end
  assign ptr_sum = {1'b0, ptr_reg} + {3'h0, ptr_step};

  // Pointer and subaddress counter; overflow moves to next cascaded device
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ptr_reg <= 6'h00;
      subaddr_reg <= 3'h0;
    end else if (byte_done && cmd_phase_reg) begin
      if (!byte_rx[6]) begin
        ptr_reg <= byte_rx[5:0];
      end else if (byte_rx[6:3] == 4'hc) begin
        subaddr_reg <= byte_rx[2:0];
      end
    end else if (byte_done) begin
      if (ptr_sum > {1'b0, lcdbk_pkg::LCDBK_RAM_LAST}) begin
        ptr_reg <= 6'(ptr_sum - 7'd40);
        subaddr_reg <= subaddr_reg + 3'h1;
      end else begin
        ptr_reg <= ptr_sum[5:0];
      end
    end
  end

  // Display RAM filling; columns beyond 39 wrap, mismatch skips storage
  always_ff @(posedge clock_i) begin
    if (byte_done && !cmd_phase_reg && sub_match) begin
      for (int i = 0; i < 8; i++) begin
        logic [5:0] col;
        logic [6:0] raw;
        raw = 7'h00;
        col = 6'h00;
        unique case (drive_mode_o)
          lcdbk_pkg::LCDBK_MODE_STATIC: begin
            raw = {1'b0, ptr_reg} + 7'(i);
            col = raw > 7'd39 ? 6'(raw - 7'd40) : raw[5:0];
            ram[col][{in_bank_reg, 1'b0}] <= byte_rx[7 - i];
          end
          lcdbk_pkg::LCDBK_MODE_MUX2: begin
            raw = {1'b0, ptr_reg} + 7'(i / 2);
            col = raw > 7'd39 ? 6'(raw - 7'd40) : raw[5:0];
            ram[col][{in_bank_reg, 1'(i % 2)}] <= byte_rx[7 - i];
          end
          lcdbk_pkg::LCDBK_MODE_MUX3: begin
            raw = {1'b0, ptr_reg} + 7'(i / 3);
            col = raw > 7'd39 ? 6'(raw - 7'd40) : raw[5:0];
            ram[col][2'(i % 3)] <= byte_rx[7 - i];
          end
          lcdbk_pkg::LCDBK_MODE_MUX4: begin
            raw = {1'b0, ptr_reg} + 7'(i / 4);
            col = raw > 7'd39 ? 6'(raw - 7'd40) : raw[5:0];
            ram[col][2'(i % 4)] <= byte_rx[7 - i];
          end
        endcase
      end
    end
  end

  lcdbk_blinker u_blinker (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .disp_tick_i(disp_tick_i),
    .rate_i(blink_rate_field_reg),
    .phase_o(blink_phase)
  );
  assign blink_phase_o = blink_phase;

  // Alternate bank only in static and 1:2 modes
  always_comb begin
    out_alt = out_bank_reg;
    if (blink_alt_reg && blink_rate_field_reg != 2'h0) begin
      out_alt = out_bank_reg ^ blink_phase;
    end
    unique case (drive_mode_o)
      lcdbk_pkg::LCDBK_MODE_STATIC: row_sel = {out_alt, 1'b0};
      lcdbk_pkg::LCDBK_MODE_MUX2: row_sel = {out_alt, bp_index_i[0]};
      lcdbk_pkg::LCDBK_MODE_MUX3: row_sel = bp_index_i == 2'h3 ? 2'h2 : bp_index_i;
      lcdbk_pkg::LCDBK_MODE_MUX4: row_sel = bp_index_i;
    endcase
  end
  assign row_word = seg_col_i > lcdbk_pkg::LCDBK_RAM_LAST ? 4'h0 : ram[seg_col_i];

  // Normal blinking blanks on phase; in 1:3/1:4 always normal
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seg_bit_o <= 1'b0;
    end else if (!disp_enable_o) begin
      seg_bit_o <= 1'b0;
    end else if (blink_phase && (!blink_alt_reg || drive_mode_o == lcdbk_pkg::LCDBK_MODE_MUX3
                 || drive_mode_o == lcdbk_pkg::LCDBK_MODE_MUX4)) begin
      seg_bit_o <= 1'b0;
    end else begin
      seg_bit_o <= row_word[row_sel];
    end
  end
endmodule : lcdbk_front
`default_nettype wire

// File: sim/lcdbk_front_sva.sv
// Port-level checks for the serial display front end
`timescale 1ns/1ps
`default_nettype none
module lcdbk_front_sva (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic slave_addr_strap_i,
  input wire logic seg_bit_o,
  input wire logic disp_enable_o,
  input wire logic [1:0] drive_mode_o,
  input wire logic bias_half_o,
  input wire logic blink_phase_o
);
  logic scl_q, sda_q, first;
  logic [3:0] cnt;
  logic [7:0] sh;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge clock_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
  end
  // Nine clocks per byte, ack slot included
  always_ff @(posedge clock_i) begin
    if (rst_i || (scl_i && scl_q && sda_q && !sda_i)) begin
      cnt <= 4'h0;
      first <= 1'b1;
    end else if (scl_i && !scl_q) begin
      sh <= {sh[6:0], sda_i};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8)
        first <= 1'b0;
    end
  end
  sda_fixed_a: assert property (sda_o == 1'b0)
    else $error("sda_o not low");
  ack_slot_a: assert property ($rose(sda_oe_o) |-> cnt == 4'h8)
    else $error("ack outside ninth clock");
  ack_addr_a: assert property ($rose(sda_oe_o) && first |->
    sh == {lcdbk_pkg::LCDBK_SLAVE_ADDR_HI, slave_addr_strap_i, 1'b0})
    else $error("ack for foreign address");
  ack_rise_a: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("ack raised with clock high");
  ack_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive moved with clock high");
  ack_end_a: assert property ($fell(scl_i) && sda_oe_o |-> ##[1:3] !sda_oe_o)
    else $error("ack not released");
  reset_out_a: assert property ($fell(rst_i) |-> !disp_enable_o && !bias_half_o
    && !blink_phase_o && !sda_oe_o && drive_mode_o == lcdbk_pkg::LCDBK_MODE_RST)
    else $error("reset values wrong");
  blank_disp_a: assert property (!disp_enable_o |=> !seg_bit_o)
    else $error("segment shown while disabled");
endmodule : lcdbk_front_sva
bind lcdbk_front lcdbk_front_sva chk (.clock_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .slave_addr_strap_i, .seg_bit_o, .disp_enable_o, .drive_mode_o, .bias_half_o,
  .blink_phase_o);
`default_nettype wire

// File: sim/lcdbk_master_model.sv
// Serial bus master model driving the display front end
`timescale 1ns/1ps
`default_nettype none
module lcdbk_master_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o = 1'b1,
  output logic sda_low_o = 1'b0,
  output logic ack_v_o = 1'b0,
  output logic ack_o = 1'b0
);
  task automatic w(input int n);
    repeat (n) @(posedge clock_i);
  endtask : w
  // Also serves as repeated start from a low clock
  task automatic start();
    sda_low_o <= 1'b0;
    w(2);
    scl_o <= 1'b1;
    w(4);
    sda_low_o <= 1'b1;
    w(4);
    scl_o <= 1'b0;
    w(2);
  endtask : start
  task automatic send(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o <= !d[i];
      w(2);
      scl_o <= 1'b1;
      w(4);
      scl_o <= 1'b0;
      w(2);
    end
    sda_low_o <= 1'b0;
    w(2);
    scl_o <= 1'b1;
    w(2);
    ack_o <= !sda_i;
    ack_v_o <= 1'b1;
    w(1);
    ack_v_o <= 1'b0;
    w(1);
    scl_o <= 1'b0;
    w(2);
  endtask : send
  task automatic stop();
    sda_low_o <= 1'b1;
    w(2);
    scl_o <= 1'b1;
    w(4);
    sda_low_o <= 1'b0;
    w(4);
  endtask : stop
endmodule : lcdbk_master_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the serial display front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b0;
  logic tick = 1'b0;
  logic seg_v = 1'b0;
  logic [2:0] sub = 3'h0;
  logic [1:0] bp = 2'h0;
  logic [5:0] col = 6'h0;
  logic [7:0] d0, d1;
  logic q[$];
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  wire logic scl, sda_low, ack_v, ack, sda_oe, seg, en, bias, ph;
  wire logic [1:0] mode;
  wire logic sda = !(sda_low || sda_oe);
  initial begin
    forever #2.5 clock_i = !clock_i;
  end
  lcdbk_front uut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .slave_addr_strap_i(strap), .hw_subaddr_pin_0_i(sub[0]),
    .hw_subaddr_pin_1_i(sub[1]), .hw_subaddr_pin_2_i(sub[2]), .disp_tick_i(tick),
    .bp_index_i(bp), .seg_col_i(col), .seg_bit_o(seg), .disp_enable_o(en),
    .drive_mode_o(mode), .bias_half_o(bias), .blink_phase_o(ph));
  lcdbk_master_model mst (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
    .ack_v_o(ack_v), .ack_o(ack));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d, input logic e);
    q.push_back(e);
    mst.send(d);
  endtask : tx
  // Each byte's bits MSB first over k rows per column
  task automatic rdb(input int c, input logic [7:0] e, input int k);
    for (int i = 0; i < 8; i++) begin
      col <= 6'(c + i / k);
      bp <= 2'(i % k);
      q.push_back(e[7 - i]);
      @(posedge clock_i);
      seg_v <= 1'b1;
      @(posedge clock_i);
      seg_v <= 1'b0;
    end
  endtask : rdb
  task automatic blink(input logic [1:0] r);
    int n;
    n = 0;
    mst.start();
    tx(8'h72, 1'b1);
    tx({6'h1c, r}, 1'b1);
    mst.stop();
    if (r == 2'h0) begin
      chk("phase", 16'h0, {15'h0, ph});
    end else begin
      @(posedge clock_i iff !ph);
      @(posedge clock_i iff ph);
      while (ph) begin
        n++;
        @(posedge clock_i);
      end
      chk("half period", 16'd768 << (r - 2'h1), 16'(n));
    end
  endtask : blink
  // Display clock tick every second cycle
  always @(posedge clock_i) begin
    tick <= !tick;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      test_done();
    end
  end
  always @(posedge clock_i) begin
    if (ack_v || seg_v) begin
      chk(ack_v ? "ack" : "seg", {15'h0, q.pop_front()}, {15'h0, ack_v ? ack : seg});
    end
  end
  initial begin
    void'($urandom(32'h727e));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk("mode", 16'h1, {14'h0, mode});
    mst.start();
    tx(8'h70, 1'b1);
    tx(8'hcd, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'he0, 1'b1);
    tx(8'h78, 1'b1);
    tx(d0, 1'b1);
    mst.start();
    tx(8'h70, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h7a, 1'b1);
    tx(d1, 1'b1);
    mst.stop();
    rdb(0, d0, 1);
    chk("enable", 16'h1, {15'h0, en});
    chk("bias", 16'h1, {15'h0, bias});
    chk("mode", 16'h1, {14'h0, mode});
    mst.start();
    tx(8'h70, 1'b1);
    tx(8'h7b, 1'b1);
    mst.stop();
    rdb(0, d1, 1);
    sub <= 3'h5;
    mst.start();
    tx(8'h70, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h61, 1'b1);
    tx(~d1, 1'b0);
    mst.stop();
    rdb(0, d1, 1);
    strap <= 1'b1;
    mst.start();
    tx(8'h70, 1'b0);
    tx(8'h80, 1'b0);
    mst.start();
    tx(8'h73, 1'b0);
    mst.start();
    tx(8'h72, 1'b1);
    tx(8'hca, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'hfb, 1'b1);
    tx(8'h65, 1'b1);
    tx(d0, 1'b1);
    tx(d1, 1'b1);
    mst.stop();
    rdb(0, d0, 2);
    rdb(4, d1, 2);
    for (int r = 1; r < 4; r++) begin
      blink(2'(r));
    end
    blink(2'h0);
    // Alternate bank blinking in 1:2, output bank alternate
    mst.start();
    tx(8'h72, 1'b1);
    tx(8'h75, 1'b1);
    mst.stop();
    @(posedge clock_i iff ph);
    @(posedge clock_i iff !ph);
    rdb(0, d0, 2);
    @(posedge clock_i iff ph);
    rdb(0, d0, 1);
    // Host rewrites RAM in 1:4 then 1:3, blinking off
    mst.start();
    tx(8'h72, 1'b1);
    tx(8'hf0, 1'b1);
    tx(8'hc8, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h65, 1'b1);
    tx(d0, 1'b1);
    tx(d1, 1'b1);
    mst.stop();
    chk("phase", 16'h0, {15'h0, ph});
    chk("mode", 16'h0, {14'h0, mode});
    rdb(0, d0, 4);
    rdb(2, d1, 4);
    mst.start();
    tx(8'h72, 1'b1);
    tx(8'hcb, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h65, 1'b1);
    tx(d1, 1'b1);
    tx(d0, 1'b1);
    mst.stop();
    rdb(0, d1, 3);
    rdb(3, d0, 3);
    mst.start();
    tx(8'h72, 1'b1);
    tx(8'h42, 1'b1);
    mst.stop();
    rdb(0, 8'h0, 2);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
